// >>> mrsd_pkg.sv
package mrsd_pkg;
   localparam int unsigned RATE_BASE = 256;
   localparam int unsigned RATE_FRAC_BITS = 28;
   localparam int unsigned RATE_ACC_W = 32;
   localparam int unsigned BW_DIV = 8;
   localparam int unsigned BW_BASE = 4;
   localparam int unsigned SYNC_W = 16;
   localparam int unsigned SYNC_LONG_W = 32;
   localparam logic [2:0] SYNC_MODE_LONG_A = 3'h3;
   localparam logic [2:0] SYNC_MODE_LONG_B = 3'h7;
   localparam logic [2:0] SYNC_MODE_OFF = 3'h0;
   localparam logic [2:0] SYNC_MODE_LOOSE = 3'h1;
   localparam logic [2:0] SYNC_MODE_CS = 3'h4;
   localparam logic [4:0] LOOSE_ERRS = 5'h01;
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam int unsigned PHASE_W = 8;
   localparam logic [7:0] PHASE_HALF = 8'h80;
   localparam logic [7:0] PHASE_NUDGE = 8'h10;
   typedef enum logic [1:0] {
      MRSD_TX_IDLE = 2'h0,
      MRSD_TX_PRE = 2'h1,
      MRSD_TX_SYNC = 2'h3,
      MRSD_TX_DATA = 2'h2
   } mrsd_tx_state_t;
endpackage : mrsd_pkg

// >>> mrsd_modem.sv
module mrsd_modem
   import mrsd_pkg::*;
#(
   parameter int unsigned MANT_W = 8,
   parameter int unsigned EXP_W = 4,
   parameter int unsigned LVL_W = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [MANT_W-1:0] i_rate_mantissa,
   input wire logic [EXP_W-1:0] i_rate_exponent,
   input wire logic [1:0] i_filter_bw_mantissa,
   input wire logic [1:0] i_filter_bw_exponent,
   input wire logic [2:0] i_sync_mode,
   input wire logic [7:0] i_sync_word_high,
   input wire logic [7:0] i_sync_word_low,
   input wire logic i_mod_ook,
   input wire logic [7:0] i_synth_offset_trim,
   input wire logic i_pq_enable,
   input wire logic [7:0] i_preamble_quality,
   input wire logic [7:0] i_pq_threshold,
   input wire logic i_carrier_sense,
   input wire logic i_rx_sample,
   input wire logic signed [7:0] i_rx_freq,
   input wire logic [LVL_W-1:0] i_rx_level,
   input wire logic i_align_release,
   input wire logic i_tx_enable,
   input wire logic [3:0] i_num_preamble,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   output logic o_tx_bit,
   output logic o_tx_bit_valid,
   output logic o_rx_bit,
   output logic o_rx_bit_valid,
   output logic o_sync_found,
   output logic o_aligned,
   output logic [7:0] o_rx_byte,
   output logic o_rx_byte_valid,
   output logic [7:0] o_offset_estimate_status,
   output logic [7:0] o_synth_offset,
   output logic [5:0] o_filter_decim,
   output logic [LVL_W-1:0] o_signal_strength
);
   // the sample and carrier-sense pins from the analog side are resynchronised first; frequency and level are used as they come
   logic rx_s1, rx_s2, rx_prev;
   logic cs_s1, cs_s2;
   logic next_rx_s1, next_rx_s2, next_rx_prev, next_cs_s1, next_cs_s2;
   logic [RATE_ACC_W-1:0] rate_acc, next_rate_acc;
   logic [RATE_ACC_W:0] rate_sum;
   logic [RATE_ACC_W-1:0] rate_step;
   logic [RATE_ACC_W-1:0] rate_mask;
   logic sym_tick;
   logic [RATE_ACC_W-1:0] phase, next_phase;
   logic rx_bit_valid, next_rx_bit_valid, rx_bit, next_rx_bit;
   logic [SYNC_LONG_W-1:0] shreg, next_shreg;
   logic [SYNC_LONG_W-1:0] pattern;
   logic long_sync;
   logic [5:0] errs;
   logic hit, qualified;
   logic aligned, next_aligned, sync_found, next_sync_found;
   logic [2:0] bitcnt, next_bitcnt;
   logic [7:0] rx_byte, next_rx_byte;
   logic rx_byte_valid, next_rx_byte_valid;
   logic signed [15:0] freq_acc, next_freq_acc;
   logic [7:0] offset_est, next_offset_est, synth_off, next_synth_off;
   logic [LVL_W-1:0] level, next_level;
   logic [5:0] decim, next_decim;
   mrsd_tx_state_t tx_state, next_tx_state;
   logic [3:0] pre_cnt, next_pre_cnt;
   logic [4:0] tx_bitcnt, next_tx_bitcnt;
   logic [SYNC_LONG_W-1:0] tx_sh, next_tx_sh;
   logic tx_bit, next_tx_bit, tx_bit_valid, next_tx_bit_valid;

   function automatic logic [5:0] mismatches(input logic [SYNC_LONG_W-1:0] a, input logic [SYNC_LONG_W-1:0] b,
                                             input logic wide);
      logic [5:0] n;
      n = '0;
      for (int i = 0; i < SYNC_LONG_W; i++) begin
         if ((wide || i < SYNC_W) && a[i] != b[i]) begin
            n = n + 6'h01;
         end
      end
      return n;
   endfunction : mismatches

   // last bit of the sync field, 16 or 32 bits long
   function automatic logic sync_done(input logic [4:0] cnt, input logic wide);
      return cnt == (wide ? 5'h1f : 5'h0f);
   endfunction : sync_done

   // phase accumulator: each wrap is one symbol; 2^28 scale kept by shifting the step
   assign rate_step = RATE_ACC_W'((RATE_ACC_W'(RATE_BASE) + RATE_ACC_W'(i_rate_mantissa)) << i_rate_exponent);
   assign rate_sum = {1'b0, rate_acc} + {1'b0, rate_step};
   assign rate_mask = RATE_ACC_W'((1 << RATE_FRAC_BITS) - 1);
   // the shared tick paces transmit; receive keeps its own edge-locked phase
   assign sym_tick = rate_sum[RATE_FRAC_BITS];
   assign long_sync = (i_sync_mode == SYNC_MODE_LONG_A) || (i_sync_mode == SYNC_MODE_LONG_B);
   assign pattern = long_sync ? {2{i_sync_word_high, i_sync_word_low}}
                              : {{SYNC_W{1'b0}}, i_sync_word_high, i_sync_word_low};
   assign errs = mismatches(shreg, pattern, long_sync);
   assign hit = (i_sync_mode != SYNC_MODE_OFF) &&
                ((i_sync_mode[1:0] == SYNC_MODE_LOOSE[1:0]) ? (errs <= 6'(LOOSE_ERRS)) : (errs == '0));
   assign qualified = hit && (!i_pq_enable || (i_preamble_quality > i_pq_threshold))
                      && (!(i_sync_mode[2] && SYNC_MODE_CS[2]) || cs_s2);

   always_comb begin
      next_rx_s1 = i_rx_sample;
      next_rx_s2 = rx_s1;
      next_rx_prev = rx_s2;
      next_cs_s1 = i_carrier_sense;
      next_cs_s2 = cs_s1;
      next_rate_acc = rate_sum[RATE_ACC_W-1:0] & rate_mask;
      next_rx_bit_valid = 1'b0;
      next_rx_bit = rx_bit;
      // every data edge restarts the bit phase and the bit is taken half a symbol later,
      // so rate error cannot pile up; line noise that flips each cycle never yields a bit
      next_phase = (phase + rate_step) & rate_mask;
      if (rx_s2 != rx_prev) begin
         next_phase = '0;
      end else if (!phase[RATE_FRAC_BITS-1] && next_phase[RATE_FRAC_BITS-1]) begin
         next_rx_bit_valid = 1'b1;
         next_rx_bit = rx_s2;
      end
      next_shreg = rx_bit_valid ? {shreg[SYNC_LONG_W-2:0], rx_bit} : shreg;
      next_sync_found = 1'b0;
      next_aligned = aligned;
      next_bitcnt = bitcnt;
      next_rx_byte = rx_byte;
      next_rx_byte_valid = 1'b0;
      if (aligned && i_align_release) begin
         next_aligned = 1'b0;
      end else if (!aligned && qualified) begin
         next_aligned = 1'b1;
         next_sync_found = 1'b1;
         next_bitcnt = '0;
      end else if (aligned && rx_bit_valid) begin
         next_rx_byte = {rx_byte[6:0], rx_bit};
         next_bitcnt = bitcnt + 3'h1;
         next_rx_byte_valid = (bitcnt == 3'h7);
      end
      // offset estimate: mean of demodulated frequency; frozen under on-off keying
      next_freq_acc = freq_acc;
      next_offset_est = offset_est;
      if (!i_mod_ook && rx_bit_valid) begin
         next_freq_acc = freq_acc - (freq_acc >>> 4) + 16'(i_rx_freq);
         next_offset_est = 8'(freq_acc >>> 4);
      end
      next_synth_off = i_mod_ook ? '0 : i_synth_offset_trim;
      next_level = level - (level >> 2) + (i_rx_level >> 2);
      // the divide-by-eight front stage is fixed, so only the scaled mantissa is reported
      next_decim = 6'((BW_BASE + 32'(i_filter_bw_mantissa)) << i_filter_bw_exponent);
      next_tx_state = tx_state;
      next_pre_cnt = pre_cnt;
      next_tx_bitcnt = tx_bitcnt;
      next_tx_sh = tx_sh;
      next_tx_bit = tx_bit;
      next_tx_bit_valid = 1'b0;
      case (tx_state)
         MRSD_TX_IDLE: begin
            if (i_tx_enable) begin
               next_tx_state = MRSD_TX_PRE;
               next_pre_cnt = '0;
               next_tx_bitcnt = '0;
               next_tx_sh = {PREAMBLE_BYTE, 24'h0};
            end
         end
         default: begin
            if (!i_tx_enable) begin
               next_tx_state = MRSD_TX_IDLE;
            end else if (sym_tick) begin
               next_tx_bit = tx_sh[SYNC_LONG_W-1];
               next_tx_bit_valid = 1'b1;
               next_tx_sh = {tx_sh[SYNC_LONG_W-2:0], 1'b0};
               next_tx_bitcnt = tx_bitcnt + 5'h01;
               if (tx_bitcnt[2:0] == 3'h7) begin
                  case (tx_state)
                     MRSD_TX_PRE: begin
                        // saturates so that a long wait for data cannot wrap the count
                        if (pre_cnt != 4'hf) begin
                           next_pre_cnt = pre_cnt + 4'h1;
                        end
                        next_tx_sh = {PREAMBLE_BYTE, 24'h0};
                        next_tx_bitcnt = '0;
                        if (({1'b0, pre_cnt} + 5'h01 >= {1'b0, i_num_preamble}) && i_tx_valid) begin
                           next_tx_state = MRSD_TX_SYNC;
                           next_tx_sh = pattern << (long_sync ? 0 : SYNC_W);
                        end
                     end
                     MRSD_TX_SYNC: begin
                        if (sync_done(tx_bitcnt, long_sync)) begin
                           next_tx_state = MRSD_TX_DATA;
                           next_tx_sh = {i_tx_data, 24'h0};
                           next_tx_bitcnt = '0;
                        end
                     end
                     default: begin
                        next_tx_bitcnt = '0;
                        // an empty buffer falls back to preamble
                        next_tx_sh = i_tx_valid ? {i_tx_data, 24'h0} : {PREAMBLE_BYTE, 24'h0};
                     end
                  endcase
               end
            end
         end
      endcase
   end

   assign o_tx_ready = i_tx_enable && sym_tick &&
                       ((tx_state == MRSD_TX_DATA && tx_bitcnt[2:0] == 3'h7) ||
                        (tx_state == MRSD_TX_SYNC && sync_done(tx_bitcnt, long_sync)));

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_prev <= 1'b0;
         cs_s1 <= 1'b0;
         cs_s2 <= 1'b0;
         rate_acc <= '0;
         phase <= '0;
         rx_bit_valid <= 1'b0;
         rx_bit <= 1'b0;
         shreg <= '0;
         sync_found <= 1'b0;
         aligned <= 1'b0;
         bitcnt <= '0;
         rx_byte <= '0;
         rx_byte_valid <= 1'b0;
         freq_acc <= '0;
         offset_est <= '0;
         synth_off <= '0;
         level <= '0;
         decim <= '0;
         tx_state <= MRSD_TX_IDLE;
         pre_cnt <= '0;
         tx_bitcnt <= '0;
         tx_sh <= '0;
         tx_bit <= 1'b0;
         tx_bit_valid <= 1'b0;
      end else begin
         rx_s1 <= next_rx_s1;
         rx_s2 <= next_rx_s2;
         rx_prev <= next_rx_prev;
         cs_s1 <= next_cs_s1;
         cs_s2 <= next_cs_s2;
         rate_acc <= next_rate_acc;
         phase <= next_phase;
         rx_bit_valid <= next_rx_bit_valid;
         rx_bit <= next_rx_bit;
         shreg <= next_shreg;
         sync_found <= next_sync_found;
         aligned <= next_aligned;
         bitcnt <= next_bitcnt;
         rx_byte <= next_rx_byte;
         rx_byte_valid <= next_rx_byte_valid;
         freq_acc <= next_freq_acc;
         offset_est <= next_offset_est;
         synth_off <= next_synth_off;
         level <= next_level;
         decim <= next_decim;
         tx_state <= next_tx_state;
         pre_cnt <= next_pre_cnt;
         tx_bitcnt <= next_tx_bitcnt;
         tx_sh <= next_tx_sh;
         tx_bit <= next_tx_bit;
         tx_bit_valid <= next_tx_bit_valid;
      end
   end

   assign o_tx_bit = tx_bit;
   assign o_tx_bit_valid = tx_bit_valid;
   assign o_rx_bit = rx_bit;
   assign o_rx_bit_valid = rx_bit_valid;
   assign o_sync_found = sync_found;
   assign o_aligned = aligned;
   assign o_rx_byte = rx_byte;
   assign o_rx_byte_valid = rx_byte_valid;
   assign o_offset_estimate_status = offset_est;
   assign o_synth_offset = synth_off;
   assign o_filter_decim = decim;
   assign o_signal_strength = level;
endmodule : mrsd_modem

// >>> mrsd_modem_props.sv
module mrsd_modem_props (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_rate_mantissa,
   input wire logic [3:0] i_rate_exponent,
   input wire logic [1:0] i_filter_bw_mantissa,
   input wire logic [1:0] i_filter_bw_exponent,
   input wire logic i_mod_ook,
   input wire logic [7:0] i_synth_offset_trim,
   input wire logic i_tx_enable,
   input wire logic i_align_release,
   input wire logic o_tx_bit_valid,
   input wire logic o_rx_bit_valid,
   input wire logic o_sync_found,
   input wire logic o_aligned,
   input wire logic o_rx_byte_valid,
   input wire logic [7:0] o_offset_estimate_status,
   input wire logic [7:0] o_synth_offset,
   input wire logic [5:0] o_filter_decim
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   a_trim_follow:
      assert property ($past(!i_rst) && !$past(i_mod_ook) |-> o_synth_offset == $past(i_synth_offset_trim))
      else $error("synth offset does not follow trim");
   a_ook_zero:
      assert property ($past(!i_rst) && $past(i_mod_ook) |-> o_synth_offset == 8'h00)
      else $error("synth offset not cleared under on-off keying");
   a_ook_freeze:
      assert property ($past(!i_rst) && $past(i_mod_ook) |-> $stable(o_offset_estimate_status))
      else $error("offset estimate moved under on-off keying");
   a_filter_bw:
      assert property ($past(!i_rst) |-> o_filter_decim ==
         6'((6'd4 + 6'($past(i_filter_bw_mantissa))) << $past(i_filter_bw_exponent)))
      else $error("filter decimation wrong");
   a_tx_pulse:
      assert property (o_tx_bit_valid |=> !o_tx_bit_valid [*8])
      else $error("tx symbols too close");
   a_tx_rate:
      assert property (o_tx_bit_valid && i_tx_enable && i_rate_mantissa == 8'hff && i_rate_exponent == 4'hf
         |-> ##[16:17] o_tx_bit_valid)
      else $error("tx symbol period wrong");
   a_rx_pulse:
      assert property (o_rx_bit_valid |=> !o_rx_bit_valid)
      else $error("rx bit strobe longer than one cycle");
   a_sync_once:
      assert property (o_sync_found |=> !o_sync_found)
      else $error("sync pulse longer than one cycle");
   a_no_resync:
      assert property ($past(!i_rst) && $past(o_aligned) && !$past(i_align_release) |-> !o_sync_found)
      else $error("sync found while aligned");
   c_sync: cover property (o_sync_found);
   c_byte: cover property (o_rx_byte_valid);
   c_tx: cover property (o_tx_bit_valid && i_tx_enable);
endmodule : mrsd_modem_props

// >>> mrsd_air_tx.sv
module mrsd_air_tx #(
   parameter int unsigned SYM = 16, // slightly off the receiver rate
   parameter logic signed [7:0] DEV = 8'sh14,
   parameter logic signed [7:0] OFS = 8'sh05
) (
   input wire logic i_clk,
   output logic o_sample,
   output logic signed [7:0] o_freq,
   output logic [7:0] o_level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy = 1'b0;
   initial o_sample = 1'b0;
   assign o_freq = o_sample ? OFS + DEV : OFS - DEV;
   assign o_level = 8'h40;
   // idle air is noise, so the line toggles each cycle instead of holding
   always @(posedge i_clk) begin
      if (!busy) begin
         o_sample <= ~o_sample;
      end
   end
   task automatic send(input logic [7:0] b, input logic last);
      busy = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         @(posedge i_clk);
         o_sample <= b[i];
         repeat (SYM - 1) @(posedge i_clk);
      end
      busy = !last;
   endtask : send
endmodule : mrsd_air_tx

// >>> testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] rm = 8'hff; // mantissa kept below 256
   logic [3:0] re = 4'hf;
   logic [1:0] bm = 2'h0, be = 2'h0;
   logic [2:0] mode = 3'h2;
   logic [7:0] hi = 8'hd3, lo = 8'h91, trim = 8'h00, pq = 8'h00, thr = 8'h00, txd = 8'h00;
   logic ook = 1'b0, pqe = 1'b0, cs = 1'b0, rel = 1'b0, txe = 1'b0, txv = 1'b0;
   logic [3:0] npre = 4'h0;
   wire logic rxs, rdy, txb, tbv, sf, byv, alg, rbit, rbv;
   wire logic signed [7:0] rxf;
   wire logic [7:0] lvl, rby, est, so, ss;
   wire logic [5:0] dec;
   int errors = 0, cmp_count = 0, nsync = 0;
   logic [7:0] last_byte = 8'h00;
   logic [31:0] tx_sr = 32'h0, want = 32'hffff_ffff;
   logic [15:0] rx_sr = 16'h0000;
   logic tx_seen = 1'b0;
   always #25 clk = ~clk;
   mrsd_air_tx air (.i_clk(clk), .o_sample(rxs), .o_freq(rxf), .o_level(lvl));
   mrsd_modem dut (.i_clk_sys(clk), .i_rst(rst), .i_rate_mantissa(rm), .i_rate_exponent(re),
      .i_filter_bw_mantissa(bm), .i_filter_bw_exponent(be), .i_sync_mode(mode), .i_sync_word_high(hi),
      .i_sync_word_low(lo), .i_mod_ook(ook), .i_synth_offset_trim(trim), .i_pq_enable(pqe),
      .i_preamble_quality(pq), .i_pq_threshold(thr), .i_carrier_sense(cs), .i_rx_sample(rxs),
      .i_rx_freq(rxf), .i_rx_level(lvl), .i_align_release(rel), .i_tx_enable(txe), .i_num_preamble(npre),
      .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(rdy), .o_tx_bit(txb), .o_tx_bit_valid(tbv),
      .o_rx_bit(rbit), .o_rx_bit_valid(rbv), .o_sync_found(sf), .o_aligned(alg), .o_rx_byte(rby),
      .o_rx_byte_valid(byv), .o_offset_estimate_status(est), .o_synth_offset(so),
      .o_filter_decim(dec), .o_signal_strength(ss));
   always @(posedge clk) begin
      if (sf === 1'b1) nsync <= nsync + 1;
      if (byv === 1'b1) last_byte <= rby;
      if (tbv === 1'b1) tx_sr <= {tx_sr[30:0], txb};
      if (rbv === 1'b1) rx_sr <= {rx_sr[14:0], rbit};
      if (tx_sr === want) tx_seen <= 1'b1;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   // one frame over the air, then alignment is handed back
   task automatic rx_frame(input logic [2:0] m, input logic [7:0] flip, input int nsw, input logic [7:0] pay,
      output int n);
      int n0;
      @(posedge clk);
      mode <= m;
      n0 = nsync;
      air.send(8'h55, 1'b0);
      air.send(8'h55, 1'b0);
      repeat (nsw) begin
         air.send(hi, 1'b0);
         air.send(lo ^ flip, 1'b0);
      end
      air.send(pay, 1'b1);
      repeat (40) @(posedge clk);
      n = nsync - n0;
      check(alg, n != 0);
      rel <= 1'b1;
      @(posedge clk);
      rel <= 1'b0;
      @(posedge clk);
      check(alg, 1'b0);
   endtask : rx_frame
   task automatic t_ctrl;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         bm <= i[1:0];
         be <= i[3:2];
         repeat (2) @(posedge clk);
         check(dec, 6'((4 + i[1:0]) << i[3:2]));
      end
      trim <= 8'h5c;
      repeat (2) @(posedge clk);
      check(so, 8'h5c);
      ook <= 1'b1;
      repeat (2) @(posedge clk);
      check(so, 8'h00);
      ook <= 1'b0;
   endtask : t_ctrl
   task automatic t_rx_basic;
      int n;
      logic [7:0] e0;
      rx_frame(3'h2, 8'h00, 1, 8'ha5, n);
      check(n, 1);
      check(last_byte, 8'ha5);
      check(rx_sr, {lo, 8'ha5});
      check($signed(est) > 0 && $signed(est) < 20, 1);
      check(ss != 8'h00, 1);
      @(posedge clk);
      ook <= 1'b1;
      @(posedge clk);
      e0 = est;
      rx_frame(3'h2, 8'h00, 1, 8'h3c, n);
      check(est, e0);
      ook <= 1'b0;
   endtask : t_rx_basic
   task automatic t_modes;
      int md [7] = '{0, 1, 2, 3, 5, 6, 7};
      int fl [7] = '{0, 4, 4, 0, 0, 0, 0};
      int nw [7] = '{1, 1, 1, 1, 1, 1, 2};
      int c [7] = '{1, 1, 1, 1, 0, 1, 1};
      int ex [7] = '{0, 1, 0, 0, 0, 1, 1};
      int n;
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         cs <= c[i][0];
         rx_frame(3'(md[i]), 8'(fl[i]), nw[i], 8'h10 + 8'(i), n);
         check(n, ex[i]);
      end
   endtask : t_modes
   task automatic t_pq;
      int n;
      @(posedge clk);
      pqe <= 1'b1;
      thr <= 8'h30;
      pq <= 8'h30;
      rx_frame(3'h2, 8'h00, 1, 8'h66, n);
      check(n, 0);
      pq <= 8'h31;
      rx_frame(3'h2, 8'h00, 1, 8'h99, n);
      check(n, 1);
      pqe <= 1'b0;
   endtask : t_pq
   task automatic t_tx;
      @(posedge clk);
      want <= {8'h55, hi, lo, 8'hc3};
      npre <= 4'h2;
      txe <= 1'b1;
      repeat (40) @(posedge clk iff tbv === 1'b1);
      #1 check(tx_sr[23:0], 24'h555555);
      @(posedge clk);
      txd <= 8'hc3;
      txv <= 1'b1;
      @(posedge clk iff rdy === 1'b1);
      txv <= 1'b0;
      repeat (40) @(posedge clk iff tbv === 1'b1);
      #1 check(tx_seen, 1'b1);
   endtask : t_tx
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_ctrl;
      t_rx_basic;
      t_modes;
      t_pq;
      t_tx;
      final_report;
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      final_report;
   end
endmodule : testbench
bind mrsd_modem mrsd_modem_props u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_rate_mantissa(i_rate_mantissa), .i_rate_exponent(i_rate_exponent), .i_mod_ook(i_mod_ook),
   .i_filter_bw_mantissa(i_filter_bw_mantissa), .i_filter_bw_exponent(i_filter_bw_exponent),
   .i_synth_offset_trim(i_synth_offset_trim), .i_tx_enable(i_tx_enable), .i_align_release(i_align_release),
   .o_tx_bit_valid(o_tx_bit_valid), .o_rx_bit_valid(o_rx_bit_valid), .o_sync_found(o_sync_found),
   .o_aligned(o_aligned), .o_rx_byte_valid(o_rx_byte_valid), .o_synth_offset(o_synth_offset),
   .o_offset_estimate_status(o_offset_estimate_status), .o_filter_decim(o_filter_decim));
